// ### dsparu_pkg.sv
// Package for the signal-processing arithmetic unit: opcodes, carriers, constants.
// Assumes one core clock; operands arrive already read from the register file.
package dsparu_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Operations and condition modes

   typedef enum logic [3:0] {
      DSPARU_OP_ADD = 4'h0,
      DSPARU_OP_SUB = 4'h1,
      DSPARU_OP_CMP = 4'h2,
      DSPARU_OP_INC = 4'h3,
      DSPARU_OP_DEC = 4'h4,
      DSPARU_OP_IADD = 4'h5,
      DSPARU_OP_ISUB = 4'h6,
      DSPARU_OP_AND = 4'h7,
      DSPARU_OP_OR = 4'h8,
      DSPARU_OP_XOR = 4'h9,
      DSPARU_OP_MUL = 4'ha,
      DSPARU_OP_ASH = 4'hb,
      DSPARU_OP_LSH = 4'hc,
      DSPARU_OP_NORM = 4'hd,
      DSPARU_OP_RND = 4'he,
      DSPARU_OP_NOP = 4'hf
   } dsparu_op_e;

   typedef enum logic [1:0] {
      DSPARU_CND_ALWAYS = 2'h0,
      DSPARU_CND_IF_SET = 2'h1,
      DSPARU_CND_IF_CLR = 2'h2
   } dsparu_cond_e;

   ////////////////////////////////////////////////////////////////////////////////
   // Status word fields and condition selection

   typedef logic [15:0] dsparu_sw_t;
   localparam int DSPARU_SW_SAT_BIT = 1;
   localparam int DSPARU_SW_CS_LSB = 5;
   localparam logic [2:0] DSPARU_CS_CARRY = 3'h0;
   localparam logic [2:0] DSPARU_CS_NEG = 3'h1;
   localparam logic [2:0] DSPARU_CS_ZERO = 3'h2;
   localparam logic [2:0] DSPARU_CS_OVF = 3'h3;
   localparam logic [2:0] DSPARU_CS_GT = 3'h4;
   localparam logic [2:0] DSPARU_CS_GE = 3'h5;

   ////////////////////////////////////////////////////////////////////////////////
   // Datapath constants

   localparam logic [6:0] DSPARU_ASH_MAX = 7'h20;
   localparam logic [6:0] DSPARU_LSH_MAX = 7'h10;
   localparam logic [6:0] DSPARU_NORM_GUARD = 7'h08;
   localparam logic [39:0] DSPARU_RND_HALF = 40'h00_0000_8000;
   localparam logic [39:0] DSPARU_INT_ONE = 40'h00_0001_0000;
   localparam logic [39:0] DSPARU_MAX_G = 40'h7f_ffff_ffff;
   localparam logic [39:0] DSPARU_MIN_G = 40'h80_0000_0000;
   localparam logic [39:0] DSPARU_MAX_U = 40'h00_7fff_ffff;
   localparam logic [39:0] DSPARU_MIN_U = 40'hff_8000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers

   typedef struct packed {
      dsparu_op_e op;
      dsparu_cond_e cond;
      logic guard;
      logic [39:0] a;
      logic [39:0] b;
      logic [6:0] amt;
   } dsparu_req_s;

   typedef struct packed {
      logic condition_flag;
      logic neg_flag;
      logic zero_flag;
      logic ovf_flag;
      logic carry_flag;
   } dsparu_flags_s;

   typedef struct packed {
      logic x_en;
      logic x_store;
      logic y_en;
      logic y_store;
      logic s_en;
      logic s_store;
      logic s_long;
      logic [15:0] x_wdata;
      logic [15:0] y_wdata;
      logic [31:0] s_wdata;
   } dsparu_xfer_s;

   typedef struct packed {
      logic x_we;
      logic [15:0] x_wdata;
      logic y_we;
      logic [15:0] y_wdata;
      logic s_we;
      logic s_long;
      logic [31:0] s_wdata;
   } dsparu_mem_s;

   typedef struct packed {
      logic x_vld;
      logic [15:0] x;
      logic y_vld;
      logic [15:0] y;
      logic s_vld;
      logic [31:0] s;
   } dsparu_load_s;

   localparam dsparu_flags_s DSPARU_FLAGS_RST = '{default: 1'b0};
   localparam dsparu_mem_s DSPARU_MEM_RST = '{default: '0};
   localparam dsparu_load_s DSPARU_LOAD_RST = '{default: '0};
   localparam logic [39:0] DSPARU_RES_RST = 40'h00_0000_0000;

endpackage

// ### dsparu_lead.sv
// Redundant sign bit counter: copies of the top bit directly below it.
// Assumes a purely combinational use inside the arithmetic unit.
`timescale 1ns/100ps
`default_nettype none

module dsparu_lead #(
   parameter int W = 40
) (
   // Value
   input wire logic [W-1:0] val_i,
   // Count
   output logic [5:0] cnt_o
);

   logic stop;

   always_comb begin
      cnt_o = 6'h00;
      stop = 1'b0;
      for (int i = W - 2; i >= 0; i--) begin
         if (!stop && (val_i[i] == val_i[W-1])) begin
            cnt_o = cnt_o + 6'h01;
         end else begin
            stop = 1'b1;
         end
      end
   end

endmodule // dsparu_lead

`default_nettype wire

// ### dsparu_core.sv
// Fixed-point signal-processing arithmetic unit with X, Y and single transfers.
// Assumes requests and status word are synchronous to clk_i; one result per cycle.
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////
module dsparu_core (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Operation request
   input wire logic req_valid_i,
   input wire dsparu_pkg::dsparu_req_s req_i,
   input wire dsparu_pkg::dsparu_sw_t status_word_i,
   // Data transfers
   input wire dsparu_pkg::dsparu_xfer_s xfer_i,
   input wire logic [15:0] xmem_rdata_i,
   input wire logic [15:0] ymem_rdata_i,
   input wire logic [31:0] smem_rdata_i,
   // Result
   output logic done_o,
   output logic res_we_o,
   output logic [39:0] res_o,
   output dsparu_pkg::dsparu_flags_s flags_o,
   // Memory side
   output dsparu_pkg::dsparu_mem_s mem_o,
   output dsparu_pkg::dsparu_load_s load_o
);

   //////////////////////////////////////////////////////////////////////////////
   // Operand preparation and adder

   logic [39:0] opa, opb, ia, ib, add_a, add_b, add_wrap;
   logic [40:0] sum41, ua, ub, usum;
   logic sub_c, add_ovf, add_car, sat_en;
   logic [2:0] cs;

   assign sat_en = status_word_i[dsparu_pkg::DSPARU_SW_SAT_BIT];
   assign cs = status_word_i[dsparu_pkg::DSPARU_SW_CS_LSB +: 3];

   always_comb begin
      opa = req_i.guard ? req_i.a : {{8{req_i.a[31]}}, req_i.a[31:0]};
      opb = req_i.guard ? req_i.b : {{8{req_i.b[31]}}, req_i.b[31:0]};
      ia = req_i.guard ? {req_i.a[39:16], 16'h0000}
                       : {{8{req_i.a[31]}}, req_i.a[31:16], 16'h0000};
      ib = req_i.guard ? {req_i.b[39:16], 16'h0000}
                       : {{8{req_i.b[31]}}, req_i.b[31:16], 16'h0000};
      unique case (req_i.op)
         dsparu_pkg::DSPARU_OP_INC, dsparu_pkg::DSPARU_OP_DEC: begin
            add_a = ia;
            add_b = dsparu_pkg::DSPARU_INT_ONE;
         end
         dsparu_pkg::DSPARU_OP_IADD, dsparu_pkg::DSPARU_OP_ISUB: begin
            add_a = ia;
            add_b = ib;
         end
         dsparu_pkg::DSPARU_OP_RND: begin
            add_a = opa;
            add_b = dsparu_pkg::DSPARU_RND_HALF;
         end
         default: begin
            add_a = opa;
            add_b = opb;
         end
      endcase
      sub_c = (req_i.op == dsparu_pkg::DSPARU_OP_SUB) || (req_i.op == dsparu_pkg::DSPARU_OP_CMP)
           || (req_i.op == dsparu_pkg::DSPARU_OP_DEC) || (req_i.op == dsparu_pkg::DSPARU_OP_ISUB);
      // One 41-bit adder keeps the exact sign, so overflow and saturation share it
      sum41 = sub_c ? ({add_a[39], add_a} - {add_b[39], add_b})
                    : ({add_a[39], add_a} + {add_b[39], add_b});
      ua = req_i.guard ? {1'b0, add_a} : {9'h000, add_a[31:0]};
      ub = req_i.guard ? {1'b0, add_b} : {9'h000, add_b[31:0]};
      usum = sub_c ? (ua - ub) : (ua + ub);
      add_car = req_i.guard ? usum[40] : usum[32];
      add_ovf = req_i.guard ? (sum41[40] != sum41[39]) : (sum41[32] != sum41[31]);
      add_wrap = req_i.guard ? sum41[39:0] : {{8{sum41[31]}}, sum41[31:0]};
   end

   //////////////////////////////////////////////////////////////////////////////
   // Shifters, multiplier, logic, normalisation detect

   logic [6:0] amag;
   logic [5:0] ash_n, lsh_n, c40, c32;
   logic shl;
   logic signed [39:0] ash_x, ash_l, ash_lw, ash_r;
   logic ash_ovf;
   logic [16:0] lsh_ext;
   logic [15:0] lsh_r, lgc_r;
   logic lsh_car;
   logic signed [31:0] prod;
   logic [6:0] ncnt;

   dsparu_lead #(.W(40)) u_lead40 (
      .val_i(opa),
      .cnt_o(c40)
   );

   dsparu_lead #(.W(32)) u_lead32 (
      .val_i(opa[31:0]),
      .cnt_o(c32)
   );

   always_comb begin
      // Amounts are two's complement; -64 still has a magnitude that fits in 7 bits
      amag = req_i.amt[6] ? (~req_i.amt + 7'h01) : req_i.amt;
      shl = !req_i.amt[6] && (req_i.amt != 7'h00);
      ash_n = (amag > dsparu_pkg::DSPARU_ASH_MAX) ? dsparu_pkg::DSPARU_ASH_MAX[5:0]
                                                  : amag[5:0];
      lsh_n = (amag > dsparu_pkg::DSPARU_LSH_MAX) ? dsparu_pkg::DSPARU_LSH_MAX[5:0]
                                                  : amag[5:0];
      ash_x = opa;
      ash_l = ash_x <<< ash_n;
      ash_lw = req_i.guard ? ash_l : {{8{ash_l[31]}}, ash_l[31:0]};
      ash_r = ash_x >>> ash_n;
      ash_ovf = shl && ((ash_lw >>> ash_n) != ash_x);
      lsh_ext = shl ? ({1'b0, req_i.a[31:16]} << lsh_n) : ({req_i.a[31:16], 1'b0} >> lsh_n);
      lsh_r = shl ? lsh_ext[15:0] : lsh_ext[16:1];
      lsh_car = (req_i.amt != 7'h00) && (shl ? lsh_ext[16] : lsh_ext[0]);
      prod = $signed(req_i.a[31:16]) * $signed(req_i.b[31:16]);
      unique case (req_i.op)
         dsparu_pkg::DSPARU_OP_AND: lgc_r = req_i.a[31:16] & req_i.b[31:16];
         dsparu_pkg::DSPARU_OP_OR: lgc_r = req_i.a[31:16] | req_i.b[31:16];
         default: lgc_r = req_i.a[31:16] ^ req_i.b[31:16];
      endcase
      // Guarded count is relative to bit 31, so guard content gives a negative shift
      if (opa == 40'h00_0000_0000) begin
         ncnt = 7'h00;
      end else if (req_i.guard) begin
         ncnt = {1'b0, c40} - dsparu_pkg::DSPARU_NORM_GUARD;
      end else begin
         ncnt = {1'b0, c32};
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Result, condition bits and transfers

   logic done_q, done_d, we_q, we_d, exec_c, upd_c, ovf_n, car_n, neg_n, zero_n, cf_n;
   logic [39:0] res_q, res_d, res_n, sat_v;
   dsparu_pkg::dsparu_flags_s flags_q, flags_d;
   dsparu_pkg::dsparu_mem_s mem_q, mem_d;
   dsparu_pkg::dsparu_load_s load_q, load_d;

   always_comb begin
      unique case (req_i.cond)
         dsparu_pkg::DSPARU_CND_ALWAYS: exec_c = 1'b1;
         dsparu_pkg::DSPARU_CND_IF_SET: exec_c = flags_q.condition_flag;
         dsparu_pkg::DSPARU_CND_IF_CLR: exec_c = !flags_q.condition_flag;
         default: exec_c = 1'b0;
      endcase
      // Multiply, no-op and conditional forms never disturb the condition bits
      upd_c = req_valid_i && (req_i.cond == dsparu_pkg::DSPARU_CND_ALWAYS)
           && (req_i.op != dsparu_pkg::DSPARU_OP_MUL)
           && (req_i.op != dsparu_pkg::DSPARU_OP_NOP);
      ovf_n = 1'b0;
      car_n = 1'b0;
      res_n = res_q;
      unique case (req_i.op)
         dsparu_pkg::DSPARU_OP_AND, dsparu_pkg::DSPARU_OP_OR, dsparu_pkg::DSPARU_OP_XOR: begin
            res_n = {{8{lgc_r[15]}}, lgc_r, 16'h0000};
         end
         dsparu_pkg::DSPARU_OP_MUL: begin
            res_n = {{8{prod[30]}}, prod[30:0], 1'b0};
         end
         dsparu_pkg::DSPARU_OP_ASH: begin
            ovf_n = ash_ovf;
            res_n = shl ? ash_lw : ash_r;
         end
         dsparu_pkg::DSPARU_OP_LSH: begin
            car_n = lsh_car;
            res_n = {{8{lsh_r[15]}}, lsh_r, 16'h0000};
         end
         dsparu_pkg::DSPARU_OP_NORM: begin
            res_n = {{17{ncnt[6]}}, ncnt, 16'h0000};
         end
         dsparu_pkg::DSPARU_OP_NOP: begin
            res_n = res_q;
         end
         default: begin
            ovf_n = add_ovf;
            car_n = add_car;
            res_n = add_wrap;
         end
      endcase
      // True sign picks the limit; shifts use the operand sign since left keeps it
      if (req_i.op == dsparu_pkg::DSPARU_OP_ASH) begin
         sat_v = ash_x[39] ? (req_i.guard ? dsparu_pkg::DSPARU_MIN_G : dsparu_pkg::DSPARU_MIN_U)
                           : (req_i.guard ? dsparu_pkg::DSPARU_MAX_G : dsparu_pkg::DSPARU_MAX_U);
      end else begin
         sat_v = sum41[40] ? (req_i.guard ? dsparu_pkg::DSPARU_MIN_G : dsparu_pkg::DSPARU_MIN_U)
                           : (req_i.guard ? dsparu_pkg::DSPARU_MAX_G : dsparu_pkg::DSPARU_MAX_U);
      end
      if (sat_en && ovf_n) begin
         res_n = sat_v;
      end
      if (req_i.op == dsparu_pkg::DSPARU_OP_RND) begin
         res_n[15:0] = 16'h0000;
      end
      neg_n = res_n[39];
      zero_n = (res_n == 40'h00_0000_0000);
      unique case (cs)
         dsparu_pkg::DSPARU_CS_CARRY: cf_n = car_n;
         dsparu_pkg::DSPARU_CS_NEG: cf_n = neg_n;
         dsparu_pkg::DSPARU_CS_ZERO: cf_n = zero_n;
         dsparu_pkg::DSPARU_CS_OVF: cf_n = ovf_n;
         dsparu_pkg::DSPARU_CS_GT: cf_n = !neg_n && !zero_n;
         dsparu_pkg::DSPARU_CS_GE: cf_n = !neg_n;
         default: cf_n = flags_q.condition_flag;
      endcase
      flags_d = flags_q;
      if (upd_c) begin
         flags_d = '{condition_flag: cf_n, neg_flag: neg_n, zero_flag: zero_n,
                     ovf_flag: ovf_n, carry_flag: car_n};
      end
      done_d = req_valid_i;
      we_d = req_valid_i && exec_c && (req_i.op != dsparu_pkg::DSPARU_OP_CMP)
          && (req_i.op != dsparu_pkg::DSPARU_OP_NOP);
      res_d = we_d ? res_n : res_q;
      // X and Y ports are independent, so both run in the same cycle
      mem_d.x_we = xfer_i.x_en && xfer_i.x_store;
      mem_d.x_wdata = xfer_i.x_wdata;
      mem_d.y_we = xfer_i.y_en && xfer_i.y_store;
      mem_d.y_wdata = xfer_i.y_wdata;
      mem_d.s_we = xfer_i.s_en && xfer_i.s_store;
      mem_d.s_long = xfer_i.s_long;
      mem_d.s_wdata = xfer_i.s_long ? xfer_i.s_wdata : {16'h0000, xfer_i.s_wdata[15:0]};
      load_d.x_vld = xfer_i.x_en && !xfer_i.x_store;
      load_d.x = xmem_rdata_i;
      load_d.y_vld = xfer_i.y_en && !xfer_i.y_store;
      load_d.y = ymem_rdata_i;
      load_d.s_vld = xfer_i.s_en && !xfer_i.s_store;
      load_d.s = xfer_i.s_long ? smem_rdata_i : {16'h0000, smem_rdata_i[15:0]};
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         done_q <= 1'b0;
         we_q <= 1'b0;
         res_q <= dsparu_pkg::DSPARU_RES_RST;
         flags_q <= dsparu_pkg::DSPARU_FLAGS_RST;
         mem_q <= dsparu_pkg::DSPARU_MEM_RST;
         load_q <= dsparu_pkg::DSPARU_LOAD_RST;
      end else begin
         done_q <= done_d;
         we_q <= we_d;
         res_q <= res_d;
         flags_q <= flags_d;
         mem_q <= mem_d;
         load_q <= load_d;
      end
   end

   assign done_o = done_q;
   assign res_we_o = we_q;
   assign res_o = res_q;
   assign flags_o = flags_q;
   assign mem_o = mem_q;
   assign load_o = load_q;

   //////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_op(dsparu_pkg::dsparu_op_e o);
      req_valid_i && (req_i.op == o) && (req_i.cond == dsparu_pkg::DSPARU_CND_ALWAYS);
   endsequence

   sequence s_quiet_flags;
      req_valid_i && (req_i.cond != dsparu_pkg::DSPARU_CND_ALWAYS);
   endsequence

   a_cmp_no_write: assert property (s_op(dsparu_pkg::DSPARU_OP_CMP) |=> done_o && !res_we_o)
      else $error("compare wrote a result");
   a_int_inc_step: assert property (s_op(dsparu_pkg::DSPARU_OP_INC) ##0 (req_i.guard && !sat_en)
      |=> res_o == {$past(req_i.a[39:16]) + 24'h00_0001, 16'h0000})
      else $error("increment result wrong");
   a_logic_and: assert property (s_op(dsparu_pkg::DSPARU_OP_AND) |=> res_o[15:0] == 16'h0000
      && res_o[31:16] == ($past(req_i.a[31:16]) & $past(req_i.b[31:16])))
      else $error("logical and result wrong");
   a_mul_flags_hold: assert property (s_op(dsparu_pkg::DSPARU_OP_MUL)
      |=> flags_o == $past(flags_o))
      else $error("multiply changed condition bits");
   a_xfer_flags_hold: assert property (!req_valid_i && (xfer_i.x_en || xfer_i.y_en || xfer_i.s_en)
      |=> $stable(flags_o))
      else $error("transfer changed condition bits");
   a_xy_parallel: assert property (xfer_i.x_en && xfer_i.y_en && !xfer_i.x_store && !xfer_i.y_store
      |=> load_o.x_vld && load_o.y_vld && load_o.x == $past(xmem_rdata_i)
      && load_o.y == $past(ymem_rdata_i))
      else $error("parallel loads lost");
   a_cond_flags_hold: assert property (s_quiet_flags |=> $stable(flags_o) ##1 1'b1)
      else $error("conditional form changed condition bits");
   a_cond_skip: assert property (req_valid_i && req_i.cond == dsparu_pkg::DSPARU_CND_IF_SET
      && !flags_o.condition_flag |=> done_o && !res_we_o && $stable(res_o))
      else $error("suppressed operation wrote a result");
   a_logic_no_ovf: assert property (s_op(dsparu_pkg::DSPARU_OP_XOR) |=> !flags_o.ovf_flag
      && !flags_o.carry_flag)
      else $error("logical class set overflow");
   a_sat_clamp: assert property (s_op(dsparu_pkg::DSPARU_OP_ADD) ##0 (sat_en && add_ovf)
      |=> res_o == dsparu_pkg::DSPARU_MAX_G || res_o == dsparu_pkg::DSPARU_MIN_G
      || res_o == dsparu_pkg::DSPARU_MAX_U || res_o == dsparu_pkg::DSPARU_MIN_U)
      else $error("overflow not saturated");
   a_guard_extend: assert property (s_op(dsparu_pkg::DSPARU_OP_SUB) ##0 !req_i.guard
      |=> res_o[39:32] == {8{res_o[31]}})
      else $error("guard bits not sign-extended");
   a_round_low: assert property (s_op(dsparu_pkg::DSPARU_OP_RND)
      |=> res_o[15:0] == 16'h0000)
      else $error("round left low bits");
   a_norm_range: assert property (s_op(dsparu_pkg::DSPARU_OP_NORM) |=> res_o[15:0] == 16'h0000
      && $signed(res_o[39:16]) >= -24'sd8 && $signed(res_o[39:16]) <= 24'sd38)
      else $error("normalise count out of range");
   a_ash_right_sign: assert property (s_op(dsparu_pkg::DSPARU_OP_ASH) ##0 (req_i.guard
      && req_i.amt == 7'h60) |=> res_o == {{32{$past(req_i.a[39])}}, $past(req_i.a[39:32])})
      else $error("right shift by 32 clamp wrong");

endmodule // dsparu_core

`default_nettype wire

// ### dsparu_mem_model.sv
// Partner model: one-word X, Y and single-transfer memories for the arithmetic unit.
// Assumes the bench drives xfer_i; stores arrive through mem_i one cycle later.
`timescale 1ns/100ps
`default_nettype none

module dsparu_mem_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Unit side
   input wire dsparu_pkg::dsparu_xfer_s xfer_i,
   input wire dsparu_pkg::dsparu_mem_s mem_i,
   output logic [15:0] xmem_rdata_o,
   output logic [15:0] ymem_rdata_o,
   output logic [31:0] smem_rdata_o
);
   logic [15:0] x_q, x_d, y_q, y_d;
   logic [31:0] s_q, s_d;

   //////////////////////////////
   always_comb begin
      x_d = mem_i.x_we ? mem_i.x_wdata : x_q;
      y_d = mem_i.y_we ? mem_i.y_wdata : y_q;
      s_d = s_q;
      if (mem_i.s_we) begin
         s_d = mem_i.s_long ? mem_i.s_wdata : {s_q[31:16], mem_i.s_wdata[15:0]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         x_q <= 16'h0;
         y_q <= 16'h0;
         s_q <= 32'h0;
      end else begin
         x_q <= x_d;
         y_q <= y_d;
         s_q <= s_d;
      end
   end

   //////////////////////////////
   // Idle read lines show the inverse, so a stale value never passes for data
   assign xmem_rdata_o = (xfer_i.x_en && !xfer_i.x_store) ? x_q : ~x_q;
   assign ymem_rdata_o = (xfer_i.y_en && !xfer_i.y_store) ? y_q : ~y_q;
   assign smem_rdata_o = (xfer_i.s_en && !xfer_i.s_store) ? s_q : ~s_q;
endmodule // dsparu_mem_model

`default_nettype wire

// ### tb_dsp_arith_unit.sv
// Testbench for the arithmetic unit with a one-word memory partner.
// Assumes the fixed one-cycle answer of the unit; all expectations are hand-worked.
`timescale 1ns/100ps
`default_nettype none

module tb_dsp_arith_unit;
   logic clk_i, rst_n_i, req_valid_i, done_o, res_we_o;
   dsparu_pkg::dsparu_req_s req_i;
   dsparu_pkg::dsparu_sw_t status_word_i;
   dsparu_pkg::dsparu_xfer_s xfer_i;
   logic [15:0] xrd, yrd;
   logic [31:0] srd;
   logic [39:0] res_o;
   dsparu_pkg::dsparu_flags_s flags_o;
   dsparu_pkg::dsparu_mem_s mem_o;
   dsparu_pkg::dsparu_load_s load_o;
   int err_total = 0;
   int samples_checked = 0;

   dsparu_core u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .status_word_i(status_word_i), .xfer_i(xfer_i), .xmem_rdata_i(xrd),
      .ymem_rdata_i(yrd), .smem_rdata_i(srd), .done_o(done_o), .res_we_o(res_we_o),
      .res_o(res_o), .flags_o(flags_o), .mem_o(mem_o), .load_o(load_o));
   dsparu_mem_model u_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .xfer_i(xfer_i), .mem_i(mem_o),
      .xmem_rdata_o(xrd), .ymem_rdata_o(yrd), .smem_rdata_o(srd));

   always #50 clk_i = ~clk_i;

   //////////////////////////////
   task automatic give_verdict();
      if (err_total == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [39:0] g, input logic [39:0] e, input string w);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t ns: %s got %h expected %h", $time, w, g, e);
      end
   endtask

   task automatic fl(input logic [4:0] e);
      cmp({35'h0, flags_o}, {35'h0, e}, "flags");
   endtask

   // One request, answered one cycle later by contract
   task automatic op(input dsparu_pkg::dsparu_op_e o, input logic [1:0] c, input logic g,
      input logic [39:0] av, input logic [39:0] bv, input logic [6:0] m, input logic we,
      input logic [39:0] e);
      @(posedge clk_i);
      #1;
      req_valid_i = 1'h1;
      req_i = '{op: o, cond: dsparu_pkg::dsparu_cond_e'(c), guard: g, a: av, b: bv, amt: m};
      @(posedge clk_i);
      #1;
      req_valid_i = 1'h0;
      cmp({38'h0, done_o, res_we_o}, {38'h0, 1'h1, we}, "done");
      cmp(res_o, e, "result");
   endtask

   task automatic xf(input dsparu_pkg::dsparu_xfer_s v);
      @(posedge clk_i);
      #1;
      xfer_i = v;
      @(posedge clk_i);
      #1;
      xfer_i = '0;
   endtask

   //////////////////////////////
   task automatic t_fixed();
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h0, 1'h1, 40'h4000_0000, 40'h4000_0000, '0, 1'h1,
         40'h8000_0000);
      fl(5'h00);
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h0, 1'h0, 40'h4000_0000, 40'h4000_0000, '0, 1'h1,
         40'hff_8000_0000);
      cmp({39'h0, flags_o.ovf_flag}, 40'h1, "overflow");
      status_word_i = 16'h0002;
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h0, 1'h0, 40'h4000_0000, 40'h4000_0000, '0, 1'h1,
         dsparu_pkg::DSPARU_MAX_U);
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h0, 1'h0, 40'h8000_0000, 40'h8000_0000, '0, 1'h1,
         dsparu_pkg::DSPARU_MIN_U);
      op(dsparu_pkg::DSPARU_OP_SUB, 2'h0, 1'h0, '0, 40'h1, '0, 1'h1, 40'hff_ffff_ffff);
      fl(5'h19);
      status_word_i = 16'h0000;
      op(dsparu_pkg::DSPARU_OP_CMP, 2'h0, 1'h1, 40'h5, 40'h5, '0, 1'h0, 40'hff_ffff_ffff);
      fl(5'h04);
      op(dsparu_pkg::DSPARU_OP_MUL, 2'h0, 1'h1, 40'h4000_0000, 40'h4000_0000, '0, 1'h1,
         40'h2000_0000);
      op(dsparu_pkg::DSPARU_OP_MUL, 2'h0, 1'h1, 40'hc000_0000, 40'h4000_0000, '0, 1'h1,
         40'hff_e000_0000);
      fl(5'h04);
   endtask

   task automatic t_int_logic();
      op(dsparu_pkg::DSPARU_OP_INC, 2'h0, 1'h1, 40'h5_1234, '0, '0, 1'h1, 40'h6_0000);
      op(dsparu_pkg::DSPARU_OP_DEC, 2'h0, 1'h0, '0, '0, '0, 1'h1, 40'hff_ffff_0000);
      op(dsparu_pkg::DSPARU_OP_IADD, 2'h0, 1'h1, 40'h2_0000, 40'h3_0000, '0, 1'h1,
         40'h5_0000);
      op(dsparu_pkg::DSPARU_OP_ISUB, 2'h0, 1'h0, 40'h2_0000, 40'h3_0000, '0, 1'h1,
         40'hff_ffff_0000);
      op(dsparu_pkg::DSPARU_OP_AND, 2'h0, 1'h1, 40'hf0f0_0000, 40'hff00_0000, '0, 1'h1,
         40'hff_f000_0000);
      op(dsparu_pkg::DSPARU_OP_OR, 2'h0, 1'h0, 40'hf0f0_0000, 40'hff00_0000, '0, 1'h1,
         40'hff_fff0_0000);
      op(dsparu_pkg::DSPARU_OP_XOR, 2'h0, 1'h0, 40'hf0f0_0000, 40'hff00_0000, '0, 1'h1,
         40'h0ff0_0000);
   endtask

   task automatic t_shift();
      op(dsparu_pkg::DSPARU_OP_ASH, 2'h0, 1'h1, 40'h1, '0, 7'h20, 1'h1, 40'h01_0000_0000);
      op(dsparu_pkg::DSPARU_OP_ASH, 2'h0, 1'h1, 40'h80_0000_0000, '0, 7'h60, 1'h1,
         40'hff_ffff_ff80);
      op(dsparu_pkg::DSPARU_OP_ASH, 2'h0, 1'h0, 40'h8000_0000, '0, 7'h7f, 1'h1,
         40'hff_c000_0000);
      op(dsparu_pkg::DSPARU_OP_ASH, 2'h0, 1'h1, 40'h1, '0, 7'h28, 1'h1, 40'h01_0000_0000);
      op(dsparu_pkg::DSPARU_OP_LSH, 2'h0, 1'h0, 40'h8001_0000, '0, 7'h01, 1'h1, 40'h2_0000);
      fl(5'h11);
      op(dsparu_pkg::DSPARU_OP_LSH, 2'h0, 1'h0, 40'h8001_0000, '0, 7'h7f, 1'h1,
         40'h4000_0000);
      op(dsparu_pkg::DSPARU_OP_LSH, 2'h0, 1'h1, 40'h8001_0000, '0, 7'h14, 1'h1, '0);
      fl(5'h15);
      op(dsparu_pkg::DSPARU_OP_NORM, 2'h0, 1'h0, 40'h1, '0, '0, 1'h1, 40'h1e_0000);
      op(dsparu_pkg::DSPARU_OP_NORM, 2'h0, 1'h1, 40'h1, '0, '0, 1'h1, 40'h1e_0000);
      op(dsparu_pkg::DSPARU_OP_NORM, 2'h0, 1'h1, 40'hff_ffff_ffff, '0, '0, 1'h1,
         40'h1f_0000);
      fl(5'h00);
      op(dsparu_pkg::DSPARU_OP_RND, 2'h0, 1'h1, 40'h1234_8000, '0, '0, 1'h1, 40'h1235_0000);
      op(dsparu_pkg::DSPARU_OP_RND, 2'h0, 1'h0, 40'h1234_7fff, '0, '0, 1'h1, 40'h1234_0000);
   endtask

   // Condition select starts on zero, so the flag follows a compare of equals; negative, greater-or-equal, greater and overflow selects follow
   task automatic t_cond();
      status_word_i = 16'h0040;
      op(dsparu_pkg::DSPARU_OP_CMP, 2'h0, 1'h1, 40'h5, 40'h5, '0, 1'h0, 40'h1234_0000);
      fl(5'h14);
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h2, 1'h1, 40'h1, 40'h1, '0, 1'h0, 40'h1234_0000);
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h1, 1'h1, 40'h1, 40'h1, '0, 1'h1, 40'h2);
      fl(5'h14);
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h3, 1'h1, 40'h1, 40'h1, '0, 1'h0, 40'h2);
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h0, 1'h1, 40'h1, 40'h2, '0, 1'h1, 40'h3);
      fl(5'h00);
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h1, 1'h1, 40'h1, 40'h1, '0, 1'h0, 40'h3);
      status_word_i = 16'h0020;
      op(dsparu_pkg::DSPARU_OP_SUB, 2'h0, 1'h1, 40'h1, 40'h2, '0, 1'h1, 40'hff_ffff_ffff);
      fl(5'h19);
      op(dsparu_pkg::DSPARU_OP_NOP, 2'h0, 1'h1, 40'h1, 40'h2, '0, 1'h0, 40'hff_ffff_ffff);
      fl(5'h19);
      status_word_i = 16'h00a0;
      op(dsparu_pkg::DSPARU_OP_SUB, 2'h0, 1'h1, 40'h1, 40'h2, '0, 1'h1, 40'hff_ffff_ffff);
      fl(5'h09);
      status_word_i = 16'h0080;
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h0, 1'h1, 40'h1, 40'h2, '0, 1'h1, 40'h3);
      fl(5'h10);
      status_word_i = 16'h0060;
      op(dsparu_pkg::DSPARU_OP_ADD, 2'h0, 1'h1, 40'h1, 40'h2, '0, 1'h1, 40'h3);
      fl(5'h00);
   endtask

   task automatic t_xfer();
      xf('{x_en: 1'h1, x_store: 1'h1, y_en: 1'h1, y_store: 1'h1, s_en: 1'h1, s_store: 1'h1,
         s_long: 1'h1, x_wdata: 16'h1234, y_wdata: 16'habcd, s_wdata: 32'h5a5a_c3c3});
      cmp({6'h0, mem_o.x_we, mem_o.x_wdata, mem_o.y_we, mem_o.y_wdata},
         {6'h0, 1'h1, 16'h1234, 1'h1, 16'habcd}, "xy store");
      cmp({6'h0, mem_o.s_we, mem_o.s_long, mem_o.s_wdata}, {6'h0, 2'h3, 32'h5a5a_c3c3},
         "single store");
      xf('{x_en: 1'h1, y_en: 1'h1, s_en: 1'h1, s_long: 1'h1, default: '0});
      cmp({6'h0, load_o.x_vld, load_o.x, load_o.y_vld, load_o.y},
         {6'h0, 1'h1, 16'h1234, 1'h1, 16'habcd}, "xy load");
      cmp({6'h0, load_o.s_vld, 1'h0, load_o.s}, {6'h0, 2'h2, 32'h5a5a_c3c3},
         "long load");
      xf('{s_en: 1'h1, default: '0});
      cmp({6'h0, load_o.x_vld, load_o.y_vld, load_o.s}, {6'h0, 2'h0, 32'hc3c3},
         "word load");
      fl(5'h00);
   endtask

   //////////////////////////////
   initial begin
      clk_i = 1'h0;
      rst_n_i = 1'h0;
      req_valid_i = 1'h0;
      req_i = '0;
      status_word_i = '0;
      xfer_i = '0;
      repeat (12) @(posedge clk_i);
      #1;
      rst_n_i = 1'h1;
      cmp(res_o, '0, "reset result");
      cmp({33'h0, done_o, res_we_o, flags_o}, '0, "reset flags");
      cmp({39'h0, |{mem_o, load_o}}, '0, "reset memory side");
      t_fixed();
      t_int_logic();
      t_shift();
      t_cond();
      t_xfer();
      give_verdict();
   end

   // Hang guard: a run far past its length counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      give_verdict();
   end
endmodule // tb_dsp_arith_unit

`default_nettype wire
